//--- design/hpcd_host_port.sv
// Host-side control, status and DMA addressing of the byte-wide host port
`timescale 1ns/1ns
`default_nettype none
`include "hpcd_defines.svh"

module hpcd_host_port (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [2:0] i_host_addr,
	input wire hpcd_pkg::hpcd_byte_t i_host_data,
	input wire logic i_host_rd_n,
	input wire logic i_host_wr_n,
	input wire logic i_host_acknowledge_in_n,
	output hpcd_pkg::hpcd_byte_t o_host_data,
	output logic o_host_data_oe,
	output logic o_host_request_out,
	output logic o_receive_request_out,
	input wire logic [2:0] i_core_dma_mode_field,
	input wire logic i_core_flag_two,
	input wire logic i_core_flag_three,
	input wire logic i_core_reset,
	input wire logic i_core_tx_write,
	input wire hpcd_pkg::hpcd_word_t i_core_tx_word,
	input wire logic i_core_rx_read,
	input wire logic i_core_cmd_ack,
	output hpcd_pkg::hpcd_word_t o_core_rx_word,
	output logic o_core_receive_full_flag,
	output logic o_core_transmit_empty_flag,
	output logic o_host_flag_zero,
	output logic o_host_flag_one,
	output logic o_command_pending_flag,
	output logic [6:0] o_command_vector_field,
	output logic [7:0] o_command_vector_addr
);
	import hpcd_pkg::*;

	function automatic hpcd_byte_t byte_of(input hpcd_word_t w, input logic [1:0] sel);
		case (sel)
			2'h0: byte_of = w[23:16];
			2'h1: byte_of = w[15:8];
			default: byte_of = w[7:0];
		endcase
	endfunction

	// =========================================================
	// Pin synchronisers
	logic [13:0] s1_q, s2_q, s3_q;
	logic [2:0] strb_q;
	wire [2:0] strb_d = (s2_q[13:11] & s3_q[13:11]) | (strb_q & (s2_q[13:11] ^ s3_q[13:11]));
	wire [2:0] bus_addr = s3_q[10:8];
	wire [7:0] bus_data = s3_q[7:0];

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= `HPCD_SYNC_RST;
			s2_q <= `HPCD_SYNC_RST;
			s3_q <= `HPCD_SYNC_RST;
			strb_q <= 3'h7;
		end else begin
			s1_q <= {i_host_acknowledge_in_n, i_host_wr_n, i_host_rd_n, i_host_addr, i_host_data};
			s2_q <= s1_q;
			s3_q <= s2_q;
			strb_q <= strb_d;
		end
	end

	wire rd_act = ~strb_q[0];
	wire rd_ev = strb_q[0] & ~strb_d[0];
	wire wr_ev = strb_q[1] & ~strb_d[1];
	wire ack_act = ~strb_q[2];
	wire ack_ev = strb_q[2] & ~strb_d[2];
	wire ack_end = ~strb_q[2] & strb_d[2];
	// Whole acknowledge window, event cycle included
	wire ack_win = ack_act | ack_ev | ack_end;

	// =========================================================
	// State
	logic rx_en_q, tx_en_q, dual_q, flag0_q, flag1_q, order_q;
	hpcd_xfer_e mode_q;
	logic [1:0] cnt_q;
	logic hc_q;
	logic [6:0] hv_q;
	logic [7:0] vaddr_q;
	logic receive_full_flag_q, transmit_empty_flag_q, core_transmit_empty_flag_q, core_receive_full_flag_q;
	hpcd_word_t rx_q, tx_q, hotx_q, horx_q;
	hpcd_byte_t dout_q;
	logic oe_q, req_pin_q, rrq_pin_q;

	// =========================================================
	// Mode decode
	wire core_none = i_core_dma_mode_field == `HPCD_CORE_MODE_NONE;
	wire core_host = i_core_dma_mode_field == `HPCD_CORE_MODE_HOST;
	wire core_ro = |i_core_dma_mode_field[1:0];
	wire dma_on = core_host && (mode_q != HPCD_XFER_INTR);
	wire little = core_none & order_q;
	wire dir_tx = tx_en_q & ~rx_en_q;
	wire dir_rx = rx_en_q & ~tx_en_q;

	// Counter substitutes the low address bits, top bit forced
	wire [2:0] acc_addr = (dma_on && ack_win) ? {1'b1, cnt_q} : bus_addr;
	wire is_data = acc_addr >= `HPCD_ADDR_DATA_FIRST;
	wire is_last = acc_addr == `HPCD_ADDR_DATA_LAST;
	wire [1:0] bsel = (acc_addr == `HPCD_ADDR_DATA_MID) ? 2'h1 :
		(((acc_addr == `HPCD_ADDR_DATA_FIRST) != little) ? 2'h0 : 2'h2);

	wire dma_wr = dma_on & dir_tx & ack_ev;
	wire dma_rd = dma_on & dir_rx & ack_ev;
	wire dat_wr = (wr_ev & is_data) | dma_wr;
	wire dat_rd = (rd_ev & is_data) | dma_rd;
	wire ctrl_wr = wr_ev && (bus_addr == `HPCD_ADDR_CTRL);
	wire cmdv_wr = wr_ev && (bus_addr == `HPCD_ADDR_CMDV);
	wire init_go = ctrl_wr & bus_data[`HPCD_CTRL_INIT];
	wire mode_wr = ctrl_wr & core_host & ~core_ro;
	wire cmd_set = cmdv_wr & bus_data[`HPCD_CMDV_REQ];
	// Initialise follows the enables written with it
	wire init_rx = init_go & bus_data[`HPCD_CTRL_RX_EN];
	wire init_tx = init_go & bus_data[`HPCD_CTRL_TX_EN];

	// Word moves between host byte registers and core side
	wire move_rx = ~core_transmit_empty_flag_q & ~receive_full_flag_q;
	wire move_tx = ~transmit_empty_flag_q & ~core_receive_full_flag_q;

	// =========================================================
	// Requests and readback
	wire req_tx = tx_en_q & transmit_empty_flag_q & (~dma_on | ~rx_en_q);
	wire req_rx = rx_en_q & receive_full_flag_q & (~dma_on | ~tx_en_q);
	wire req_any = req_tx | req_rx;
	wire req_pin_d = dual_q ? req_tx : req_any;
	wire rrq_pin_d = dual_q & req_rx;

	wire [1:0] bits65 = core_ro ? i_core_dma_mode_field[1:0] :
		(core_host ? mode_q : {1'b0, order_q});
	wire [7:0] ctrl_rd = {1'b0, bits65, flag1_q, flag0_q, dual_q & ~core_host, tx_en_q, rx_en_q};
	wire [7:0] stat_rd = {req_any, 2'b00, i_core_flag_three, i_core_flag_two,
		transmit_empty_flag_q & ~core_receive_full_flag_q, transmit_empty_flag_q, receive_full_flag_q};
	wire [7:0] reg_rd = (acc_addr == `HPCD_ADDR_CTRL) ? ctrl_rd :
		(acc_addr == `HPCD_ADDR_CMDV) ? {hc_q, hv_q} :
		(acc_addr == `HPCD_ADDR_STAT) ? stat_rd :
		is_data ? byte_of(rx_q, bsel) : 8'h00;
	wire dma_drive = dma_on & dir_rx & ack_act;
	wire oe_d = (rd_act & ~dma_on) | (rd_act & ~ack_act) | dma_drive;

	// =========================================================
	// Control register
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_en_q <= 1'b0;
			tx_en_q <= 1'b0;
			dual_q <= 1'b0;
			flag0_q <= 1'b0;
			flag1_q <= 1'b0;
			order_q <= 1'b0;
			mode_q <= HPCD_XFER_INTR;
		end else if (ctrl_wr) begin
			rx_en_q <= bus_data[`HPCD_CTRL_RX_EN];
			tx_en_q <= bus_data[`HPCD_CTRL_TX_EN];
			dual_q <= bus_data[`HPCD_CTRL_DUAL];
			flag0_q <= bus_data[`HPCD_CTRL_FLAG0];
			flag1_q <= bus_data[`HPCD_CTRL_FLAG1];
			if (core_none) begin
				order_q <= bus_data[`HPCD_CTRL_ORDER];
			end
			if (mode_wr) begin
				mode_q <= hpcd_xfer_e'(bus_data[`HPCD_CTRL_MODE_HI:`HPCD_CTRL_MODE_LO]);
			end
		end
	end

	// =========================================================
	// DMA address counter
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 2'h0;
		end else if (init_go || mode_wr) begin
			cnt_q <= mode_wr ? bus_data[`HPCD_CTRL_MODE_HI:`HPCD_CTRL_MODE_LO] : mode_q;
		end else if (dma_on && ack_end && (dir_tx || dir_rx)) begin
			cnt_q <= (cnt_q == `HPCD_CNT_LAST) ? mode_q : cnt_q + 2'h1;
		end
	end

	// =========================================================
	// Command vector
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hc_q <= 1'b0;
			hv_q <= `HPCD_VECTOR_RST;
			vaddr_q <= {`HPCD_VECTOR_RST, 1'b0};
		end else if (i_core_reset) begin
			hc_q <= 1'b0;
			hv_q <= `HPCD_VECTOR_RST;
			vaddr_q <= {`HPCD_VECTOR_RST, 1'b0};
		end else begin
			if (cmdv_wr) begin
				hv_q <= bus_data[6:0];
				vaddr_q <= {bus_data[6:0], 1'b0};
			end
			if (cmd_set) begin
				hc_q <= 1'b1;
			end else if (i_core_cmd_ack) begin
				hc_q <= 1'b0;
			end
		end
	end

	// =========================================================
	// Data words and transfer flags
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			receive_full_flag_q <= 1'b0;
			transmit_empty_flag_q <= 1'b1;
			core_transmit_empty_flag_q <= 1'b1;
			core_receive_full_flag_q <= 1'b0;
			rx_q <= 24'h000000;
			tx_q <= 24'h000000;
			hotx_q <= 24'h000000;
			horx_q <= 24'h000000;
		end else begin
			if (dat_wr) begin
				case (bsel)
					2'h0: tx_q[23:16] <= bus_data;
					2'h1: tx_q[15:8] <= bus_data;
					default: tx_q[7:0] <= bus_data;
				endcase
				if (is_last) begin
					transmit_empty_flag_q <= 1'b0;
				end
			end
			if (dat_rd && is_last) begin
				receive_full_flag_q <= 1'b0;
			end
			if (i_core_tx_write) begin
				core_transmit_empty_flag_q <= 1'b0;
				hotx_q <= i_core_tx_word;
			end
			if (i_core_rx_read) begin
				core_receive_full_flag_q <= 1'b0;
			end
			if (init_rx) begin
				receive_full_flag_q <= 1'b0;
				core_transmit_empty_flag_q <= 1'b1;
			end
			if (init_tx) begin
				transmit_empty_flag_q <= 1'b1;
				core_receive_full_flag_q <= 1'b0;
			end
			if (move_rx) begin
				rx_q <= hotx_q;
				receive_full_flag_q <= 1'b1;
				core_transmit_empty_flag_q <= 1'b1;
			end
			if (move_tx) begin
				horx_q <= tx_q;
				transmit_empty_flag_q <= 1'b1;
				core_receive_full_flag_q <= 1'b1;
			end
		end
	end

	// =========================================================
	// Pins
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dout_q <= 8'h00;
			oe_q <= 1'b0;
			req_pin_q <= 1'b0;
			rrq_pin_q <= 1'b0;
		end else begin
			dout_q <= reg_rd;
			oe_q <= oe_d;
			req_pin_q <= req_pin_d;
			rrq_pin_q <= rrq_pin_d;
		end
	end

	assign o_host_data = dout_q;
	assign o_host_data_oe = oe_q;
	assign o_host_request_out = req_pin_q;
	assign o_receive_request_out = rrq_pin_q;
	assign o_core_rx_word = horx_q;
	assign o_core_receive_full_flag = core_receive_full_flag_q;
	assign o_core_transmit_empty_flag = core_transmit_empty_flag_q;
	assign o_host_flag_zero = flag0_q;
	assign o_host_flag_one = flag1_q;
	assign o_command_pending_flag = hc_q;
	assign o_command_vector_field = hv_q;
	assign o_command_vector_addr = vaddr_q;
endmodule
`default_nettype wire

//--- design/hpcd_defines.svh
// Offsets, field positions and reset values of the host port control block
`ifndef HPCD_DEFINES_SVH
`define HPCD_DEFINES_SVH

`define HPCD_ADDR_CTRL 3'h0
`define HPCD_ADDR_CMDV 3'h1
`define HPCD_ADDR_STAT 3'h2
`define HPCD_ADDR_DATA_FIRST 3'h5
`define HPCD_ADDR_DATA_MID 3'h6
`define HPCD_ADDR_DATA_LAST 3'h7

`define HPCD_CTRL_RX_EN 0
`define HPCD_CTRL_TX_EN 1
`define HPCD_CTRL_DUAL 2
`define HPCD_CTRL_FLAG0 3
`define HPCD_CTRL_FLAG1 4
`define HPCD_CTRL_ORDER 5
`define HPCD_CTRL_MODE_LO 5
`define HPCD_CTRL_MODE_HI 6
`define HPCD_CTRL_INIT 7
`define HPCD_CMDV_REQ 7

`define HPCD_VECTOR_RST 7'h32
`define HPCD_CORE_MODE_NONE 3'h0
`define HPCD_CORE_MODE_HOST 3'h4
`define HPCD_CNT_LAST 2'h3
`define HPCD_SYNC_RST 14'h3F00

`endif

//--- design/hpcd_pkg.sv
// Types shared by the host port control block
package hpcd_pkg;
	typedef logic [7:0] hpcd_byte_t;
	typedef logic [23:0] hpcd_word_t;
	typedef enum logic [1:0] {
		HPCD_XFER_INTR,
		HPCD_XFER_DMA24,
		HPCD_XFER_DMA16,
		HPCD_XFER_DMA8
	} hpcd_xfer_e;
endpackage

//--- sim/hpcd_host_port_assertions.sv
// Port checks for the host port control block
`timescale 1ns/1ns
`default_nettype none
module hpcd_host_port_assertions (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_host_rd_n,
	input wire logic i_host_wr_n,
	input wire logic i_host_acknowledge_in_n,
	input wire logic i_core_reset,
	input wire logic i_core_cmd_ack,
	input wire logic o_host_data_oe,
	input wire logic o_core_transmit_empty_flag,
	input wire logic o_host_flag_zero,
	input wire logic o_host_flag_one,
	input wire logic o_command_pending_flag,
	input wire logic [6:0] o_command_vector_field,
	input wire logic [7:0] o_command_vector_addr
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	// ====
	// No host write event can still be in flight
	sequence host_quiet;
		i_host_wr_n [*6];
	endsequence
	vector_addr_a: assert property (o_command_vector_addr == {o_command_vector_field, 1'h0})
		else $error("vector address wrong");
	reset_values_a: assert property ($rose(i_rst_n) |-> o_command_vector_field == 7'h32 && o_core_transmit_empty_flag)
		else $error("reset values wrong");
	core_reset_a: assert property (host_quiet ##0 i_core_reset |=> o_command_vector_field == 7'h32)
		else $error("core reset missed");
	pend_clear_a: assert property (host_quiet ##0 i_core_cmd_ack |=> !o_command_pending_flag)
		else $error("command bit not cleared");
	pend_hold_a: assert property (o_command_pending_flag && !i_core_cmd_ack && !i_core_reset |=> o_command_pending_flag)
		else $error("command bit lost");
	flags_kept_a: assert property (host_quiet |-> $stable({o_host_flag_zero, o_host_flag_one}))
		else $error("host flags changed");
	read_drive_a: assert property ($fell(i_host_rd_n) |-> ##[3:5] o_host_data_oe)
		else $error("read not driven");
	bus_idle_a: assert property ((i_host_rd_n && i_host_acknowledge_in_n) [*6] |-> !o_host_data_oe)
		else $error("bus driven while idle");
endmodule
bind hpcd_host_port hpcd_host_port_assertions u_checks (.*);
`default_nettype wire

//--- sim/hpcd_host_model.sv
// Host processor model on the byte-wide host bus
`timescale 1ns/1ns
`default_nettype none
module hpcd_host_model (
	input wire logic i_clock,
	input wire logic [7:0] i_bus_data,
	output logic [2:0] o_addr,
	output logic [7:0] o_data,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_ack_n
);
	initial begin
		o_addr = 3'h0;
		o_data = 8'h00;
		o_rd_n = 1'h1;
		o_wr_n = 1'h1;
		o_ack_n = 1'h1;
	end
	// ====
	// Access kind 0 write, 1 read, 2 acknowledge; data held while strobe low
	task automatic cycle(input logic [2:0] a, input logic [7:0] d, input logic [1:0] k, output logic [7:0] q);
		@(posedge i_clock);
		o_addr <= a;
		o_data <= d;
		o_wr_n <= k != 2'h0;
		o_rd_n <= k != 2'h1;
		o_ack_n <= k != 2'h2;
		repeat (5) @(posedge i_clock);
		@(negedge i_clock);
		q = i_bus_data;
		@(posedge i_clock);
		o_rd_n <= 1'h1;
		o_wr_n <= 1'h1;
		o_ack_n <= 1'h1;
		o_data <= ~d;
		repeat (6) @(posedge i_clock);
	endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the host port control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import hpcd_pkg::*;
	logic i_clock, i_rst_n, rd_n, wr_n, ack_n, oe, req, rrq, rf, te, hf0, hf1, pend;
	logic [2:0] core_mode, h_addr;
	logic [1:0] core_flags;
	logic [3:0] pls;
	hpcd_byte_t h_wdata, h_rdata, q, vaddr;
	logic [6:0] vec;
	hpcd_word_t rx_word;
	int mismatches, comparisons;
	hpcd_host_model host (.i_clock, .i_bus_data(h_rdata), .o_addr(h_addr), .o_data(h_wdata), .o_rd_n(rd_n),
		.o_wr_n(wr_n), .o_ack_n(ack_n));
	hpcd_host_port dut (.i_clock, .i_rst_n, .i_host_addr(h_addr), .i_host_data(h_wdata), .i_host_rd_n(rd_n),
		.i_host_wr_n(wr_n), .i_host_acknowledge_in_n(ack_n), .o_host_data(h_rdata), .o_host_data_oe(oe),
		.o_host_request_out(req), .o_receive_request_out(rrq), .i_core_dma_mode_field(core_mode),
		.i_core_flag_two(core_flags[0]), .i_core_flag_three(core_flags[1]), .i_core_reset(pls[0]),
		.i_core_tx_write(pls[1]), .i_core_tx_word(24'h5A6B7C), .i_core_rx_read(pls[2]), .i_core_cmd_ack(pls[3]),
		.o_core_rx_word(rx_word), .o_core_receive_full_flag(rf), .o_core_transmit_empty_flag(te),
		.o_host_flag_zero(hf0), .o_host_flag_one(hf1), .o_command_pending_flag(pend),
		.o_command_vector_field(vec), .o_command_vector_addr(vaddr));
	initial begin
		i_clock = 1'h0;
		forever #5 i_clock = ~i_clock;
	end
	// ====
	// Bus and compare helpers
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host.cycle(a, d, 2'h0, q);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		host.cycle(a, 8'h00, 2'h1, q);
		chk({16'h0000, q}, {16'h0000, e});
	endtask
	task automatic dma(input logic [7:0] d);
		host.cycle(3'h0, d, 2'h2, q);
	endtask
	task automatic pulse(input logic [3:0] p);
		@(posedge i_clock);
		pls <= p;
		@(posedge i_clock);
		pls <= 4'h0;
		repeat (3) @(posedge i_clock);
	endtask
	task automatic sf(input logic [6:0] e);
		chk({17'h00000, req, rrq, rf, te, hf0, hf1, pend}, {17'h00000, e});
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge i_clock);
		mismatches++;
		report_and_stop;
	end
	initial begin
		i_rst_n = 1'h0;
		core_mode = 3'h0;
		core_flags = 2'h2;
		pls = 4'h0;
		mismatches = 0;
		comparisons = 0;
		repeat (5) @(posedge i_clock);
		i_rst_n <= 1'h1;
		sf(7'h08);
		chk({9'h000, vec, vaddr}, 24'h003264);
		rd(3'h2, 8'h16);
		pulse(4'h2);
		wr(3'h0, 8'h05);
		sf(7'h28);
		rd(3'h5, 8'h5A);
		rd(3'h7, 8'h7C);
		wr(3'h0, 8'h1A);
		sf(7'h4E);
		rd(3'h2, 8'h96);
		wr(3'h0, 8'h60);
		rd(3'h0, 8'h20);
		wr(3'h5, 8'h33);
		wr(3'h6, 8'h22);
		wr(3'h7, 8'h11);
		chk(rx_word, 24'h112233);
		sf(7'h18);
		pulse(4'h2);
		pulse(4'h2);
		wr(3'h0, 8'h81);
		sf(7'h18);
		wr(3'h0, 8'h82);
		sf(7'h48);
		rd(3'h0, 8'h02);
		wr(3'h1, 8'h85);
		sf(7'h49);
		chk({9'h000, vec, vaddr}, 24'h00050A);
		rd(3'h1, 8'h85);
		pulse(4'h8);
		rd(3'h1, 8'h05);
		wr(3'h2, 8'hFF);
		rd(3'h0, 8'h02);
		sf(7'h48);
		core_mode <= 3'h4;
		wr(3'h0, 8'h22);
		rd(3'h0, 8'h22);
		dma(8'hA1);
		dma(8'hA2);
		dma(8'hA3);
		chk(rx_word, 24'hA1A2A3);
		pulse(4'h4);
		wr(3'h0, 8'h62);
		dma(8'hB4);
		chk(rx_word, 24'hA1A2B4);
		pulse(4'h4);
		dma(8'hC5);
		chk(rx_word, 24'hA1A2C5);
		wr(3'h0, 8'h61);
		pulse(4'h2);
		dma(8'h00);
		chk({16'h0000, q}, 24'h00007C);
		core_mode <= 3'h1;
		rd(3'h0, 8'h21);
		pulse(4'h1);
		chk({9'h000, vec, vaddr}, 24'h003264);
		report_and_stop;
	end
endmodule
`default_nettype wire
